// ---- common/sdbg_regs.svh ----
`ifndef SDBG_REGS_SVH
`define SDBG_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SDBG_ADDR_DATA     8'h18
`define SDBG_ADDR_BAUD     8'h1c
`define SDBG_ADDR_OPTION   8'h20
`define SDBG_ADDR_STATUS   8'h24
`define SDBG_ADDR_IRQ_STAT 8'h28
`define SDBG_ADDR_IRQ_CLR  8'h2c
`define SDBG_ADDR_IRQ_EN   8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SDBG_BAUD_PSEL_HI  5
`define SDBG_BAUD_PSEL_LO  4
`define SDBG_BAUD_RSEL_HI  2
`define SDBG_BAUD_RSEL_LO  0
`define SDBG_OPT_SRC_BIT   0
`define SDBG_STAT_TXE_BIT  7
`define SDBG_STAT_RXF_BIT  5
`define SDBG_IRQ_RXF_BIT   0
`define SDBG_IRQ_TXE_BIT   1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SDBG_RST_PSEL      2'h0
`define SDBG_RST_RSEL      3'h0
`define SDBG_RST_SRC       1'h0
`define SDBG_RST_TXE       1'h1
`define SDBG_RST_RXF       1'h0
`define SDBG_RST_IRQ       2'h0

// ----------------------------------------------------------------------
// Divider constants
// ----------------------------------------------------------------------
`define SDBG_PD_CODE0      4'h1
`define SDBG_PD_CODE1      4'h3
`define SDBG_PD_CODE2      4'h4
`define SDBG_PD_CODE3      4'hd
`define SDBG_POST_LAST     6'h3f
`define SDBG_POST_X16_MASK 6'h03
`define SDBG_POST_X32_MASK 6'h01

`endif

// ---- common/sdbg_pkg.sv ----
package sdbg_pkg;

  typedef logic [1:0] sdbg_psel_t;
  typedef logic [2:0] sdbg_rsel_t;
  typedef logic [7:0] sdbg_byte_t;

  typedef enum logic {
    sdbg_src_bus,
    sdbg_src_crystal
  } sdbg_src_t;

endpackage : sdbg_pkg

// ---- common/sdbg_div_if.sv ----
`timescale 1ns/1ps

interface sdbg_div_if;
  import sdbg_pkg::*;

  sdbg_psel_t psel;
  sdbg_rsel_t rsel;
  logic       src_tick;
  logic       tick_x32;
  logic       tick_x16;
  logic       bit_tick;

  modport ctrl (
    output psel,
    output rsel,
    output src_tick,
    input  tick_x32,
    input  tick_x16,
    input  bit_tick
  );

  modport div (
    input  psel,
    input  rsel,
    input  src_tick,
    output tick_x32,
    output tick_x16,
    output bit_tick
  );
endinterface : sdbg_div_if

// ---- logic/sdbg_baud_div.sv ----
`timescale 1ns/1ps
`include "sdbg_regs.svh"

module sdbg_baud_div
  import sdbg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Divider link
  sdbg_div_if.div  dv
);

  logic [3:0] pre_cnt_reg;
  logic [3:0] pre_cnt_next;
  logic [7:0] rate_cnt_reg;
  logic [7:0] rate_cnt_next;
  logic [5:0] post_cnt_reg;
  logic [5:0] post_cnt_next;
  logic       x32_reg;
  logic       x32_next;
  logic       x16_reg;
  logic       x16_next;
  logic       bit_reg;
  logic       bit_next;
  logic [3:0] pd;
  logic [7:0] bd;
  logic       pre_tick;
  logic       rate_tick;

  // ----------------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (dv.psel)
      2'h0: pd = `SDBG_PD_CODE0; // RL7
      2'h1: pd = `SDBG_PD_CODE1; // RL7
      2'h2: pd = `SDBG_PD_CODE2; // RL7
      2'h3: pd = `SDBG_PD_CODE3; // RL7
    endcase
    bd = 8'h01 << dv.rsel; // RL9
    pre_tick = dv.src_tick && (pre_cnt_reg >= pd - 4'h1);
    rate_tick = pre_tick && (rate_cnt_reg >= bd - 8'h01);
    pre_cnt_next = pre_cnt_reg;
    rate_cnt_next = rate_cnt_reg;
    post_cnt_next = post_cnt_reg;
    if (dv.src_tick) begin
      pre_cnt_next = pre_tick ? 4'h0 : pre_cnt_reg + 4'h1;
    end
    if (pre_tick) begin
      rate_cnt_next = rate_tick ? 8'h00 : rate_cnt_reg + 8'h01;
    end
    if (rate_tick) begin
      post_cnt_next = post_cnt_reg + 6'h01;
    end
    x32_next = rate_tick &&
      ((post_cnt_reg & `SDBG_POST_X32_MASK) == `SDBG_POST_X32_MASK);
    x16_next = rate_tick &&
      ((post_cnt_reg & `SDBG_POST_X16_MASK) == `SDBG_POST_X16_MASK); // RL15
    bit_next = rate_tick && (post_cnt_reg == `SDBG_POST_LAST); // RL10
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_cnt_reg  <= 4'h0;
      rate_cnt_reg <= 8'h00;
      post_cnt_reg <= 6'h00;
      x32_reg      <= 1'b0;
      x16_reg      <= 1'b0;
      bit_reg      <= 1'b0;
    end else begin
      pre_cnt_reg  <= pre_cnt_next;
      rate_cnt_reg <= rate_cnt_next;
      post_cnt_reg <= post_cnt_next;
      x32_reg      <= x32_next;
      x16_reg      <= x16_next;
      bit_reg      <= bit_next;
    end
  end

  assign dv.tick_x32 = x32_reg;
  assign dv.tick_x16 = x16_reg;
  assign dv.bit_tick = bit_reg;

endmodule : sdbg_baud_div

// ---- logic/sdbg_top.sv ----
// What this block does
// RL1 - One byte-wide data buffer at 18h links the bus to both shifters.
// RL2 - A data buffer read returns the last received byte, read-only.
// RL3 - A data buffer write loads the next byte to send, sparing the rx byte.
// RL4 - Reset leaves both bytes of the data buffer unchanged.
// RL5 - Software should not use read-modify-write on the data buffer.
// RL6 - One baud-select register sets the rate for both directions.
// RL7 - The prescale field picks a divisor of 1, 3, 4 or 13 for codes 0 to 3.
// RL8 - Reset clears the prescale field; both its bits stay read-write.
// RL9 - The rate field picks a divisor of two to its value and resets to 0.
// RL10 - The bit rate is the source clock over 64 times both divisors.
// RL11 - An option bit selects the bus clock or crystal reference as source.
// RL12 - The system keeps the bus clock at least 32 times the bit rate.
// RL13 - A data write after a status read that saw tx empty clears it.
// RL14 - A data read after a status read that saw rx full clears it.
// RL15 - A 16x tick runs at the source over 4 times both divisors.
`timescale 1ns/1ps
`include "sdbg_regs.svh"

module sdbg_top
  import sdbg_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // Clock source
  input  wire logic        crystal_ref_clock,
  // Shift register side
  input  wire logic        rx_load,
  input  wire logic [7:0]  rx_shift_byte,
  input  wire logic        tx_take,
  output      logic [7:0]  tx_byte_bits,
  output      logic        tx_pending,
  // Baud ticks
  output      logic        baud_tick_x32,
  output      logic        baud_tick_x16,
  output      logic        baud_bit_tick,
  // Interrupt
  output      logic        irq
);

  sdbg_div_if dvi ();

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  sdbg_psel_t  psel_reg;
  sdbg_psel_t  psel_next;
  sdbg_rsel_t  rsel_reg;
  sdbg_rsel_t  rsel_next;
  sdbg_src_t   src_reg;
  sdbg_src_t   src_next;
  logic        txe_reg;
  logic        txe_next;
  logic        rxf_reg;
  logic        rxf_next;
  logic        tx_arm_reg;
  logic        tx_arm_next;
  logic        rx_arm_reg;
  logic        rx_arm_next;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_stat_next;
  logic [1:0]  irq_en_reg;
  logic [1:0]  irq_en_next;
  sdbg_byte_t  rx_byte_reg;
  sdbg_byte_t  rx_byte_next;
  sdbg_byte_t  tx_byte_reg;
  sdbg_byte_t  tx_byte_next;
  logic        xtal_reg;
  logic        xtal_prev_reg;
  logic        acc_rd;
  logic        acc_wr;
  logic        lane0;
  logic [1:0]  irq_ev;
  logic        wr_data;
  logic        rd_data;
  logic        rd_status;

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign acc_rd = avs_read && ack_reg;
  assign acc_wr = avs_write && ack_reg;
  assign lane0 = avs_byteenable[0];
  assign wr_data = acc_wr && lane0 && avs_address == `SDBG_ADDR_DATA;
  assign rd_data = acc_rd && avs_address == `SDBG_ADDR_DATA;
  assign rd_status = acc_rd && avs_address == `SDBG_ADDR_STATUS;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_comb begin
    ack_next = (avs_read || avs_write) && !ack_reg;
    rdata_next = 32'h0000_0000;
    unique case (avs_address)
      `SDBG_ADDR_DATA: rdata_next[7:0] = rx_byte_reg; // RL2
      `SDBG_ADDR_BAUD: begin
        rdata_next[`SDBG_BAUD_PSEL_HI:`SDBG_BAUD_PSEL_LO] = psel_reg; // RL8
        rdata_next[`SDBG_BAUD_RSEL_HI:`SDBG_BAUD_RSEL_LO] = rsel_reg;
      end
      `SDBG_ADDR_OPTION: rdata_next[`SDBG_OPT_SRC_BIT] = src_reg;
      `SDBG_ADDR_STATUS: begin
        rdata_next[`SDBG_STAT_TXE_BIT] = txe_reg;
        rdata_next[`SDBG_STAT_RXF_BIT] = rxf_reg;
      end
      `SDBG_ADDR_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
      `SDBG_ADDR_IRQ_EN: rdata_next[1:0] = irq_en_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata = rdata_reg;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_comb begin
    psel_next = psel_reg;
    rsel_next = rsel_reg;
    src_next = src_reg;
    irq_en_next = irq_en_reg;
    if (acc_wr && lane0) begin
      unique case (avs_address)
        `SDBG_ADDR_BAUD: begin
          psel_next =
            avs_writedata[`SDBG_BAUD_PSEL_HI:`SDBG_BAUD_PSEL_LO]; // RL8
          rsel_next =
            avs_writedata[`SDBG_BAUD_RSEL_HI:`SDBG_BAUD_RSEL_LO]; // RL6
        end
        `SDBG_ADDR_OPTION: begin
          src_next = sdbg_src_t'(avs_writedata[`SDBG_OPT_SRC_BIT]); // RL11
        end
        `SDBG_ADDR_IRQ_EN: irq_en_next = avs_writedata[1:0];
        default: irq_en_next = irq_en_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      psel_reg   <= `SDBG_RST_PSEL; // RL8
      rsel_reg   <= `SDBG_RST_RSEL; // RL9
      src_reg    <= sdbg_src_t'(`SDBG_RST_SRC);
      irq_en_reg <= `SDBG_RST_IRQ;
    end else begin
      psel_reg   <= psel_next;
      rsel_reg   <= rsel_next;
      src_reg    <= src_next;
      irq_en_reg <= irq_en_next;
    end
  end

  // ----------------------------------------------------------------------
  // Data buffer
  // ----------------------------------------------------------------------
  always_comb begin
    rx_byte_next = rx_byte_reg;
    tx_byte_next = tx_byte_reg;
    if (rx_load) begin
      rx_byte_next = rx_shift_byte; // RL1
    end
    if (wr_data) begin
      tx_byte_next = avs_writedata[7:0]; // RL3
    end
  end

  always_ff @(posedge sys_clk) begin
    rx_byte_reg <= rx_byte_next; // RL4
    tx_byte_reg <= tx_byte_next; // RL4
  end

  assign tx_byte_bits = tx_byte_reg;

  // ----------------------------------------------------------------------
  // Buffer flags
  // ----------------------------------------------------------------------
  always_comb begin
    txe_next = txe_reg;
    rxf_next = rxf_reg;
    tx_arm_next = tx_arm_reg;
    rx_arm_next = rx_arm_reg;
    if (rd_status) begin
      tx_arm_next = txe_reg;
      rx_arm_next = rxf_reg;
    end
    if (wr_data) begin
      tx_arm_next = 1'b0;
      if (tx_arm_reg) begin
        txe_next = 1'b0; // RL13
      end
    end
    if (rd_data) begin
      rx_arm_next = 1'b0;
      if (rx_arm_reg) begin
        rxf_next = 1'b0; // RL14
      end
    end
    if (tx_take) begin
      txe_next = 1'b1;
    end
    if (rx_load) begin
      rxf_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txe_reg    <= `SDBG_RST_TXE;
      rxf_reg    <= `SDBG_RST_RXF;
      tx_arm_reg <= 1'b0;
      rx_arm_reg <= 1'b0;
    end else begin
      txe_reg    <= txe_next;
      rxf_reg    <= rxf_next;
      tx_arm_reg <= tx_arm_next;
      rx_arm_reg <= rx_arm_next;
    end
  end

  assign tx_pending = !txe_reg;

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_ev = 2'h0;
    irq_ev[`SDBG_IRQ_RXF_BIT] = rx_load;
    irq_ev[`SDBG_IRQ_TXE_BIT] = tx_take;
    irq_stat_next = irq_stat_reg;
    if (acc_wr && lane0 && avs_address == `SDBG_ADDR_IRQ_CLR) begin
      irq_stat_next = irq_stat_reg & ~avs_writedata[1:0];
    end
    irq_stat_next = irq_stat_next | irq_ev;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_reg <= `SDBG_RST_IRQ;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_en_reg);

  // ----------------------------------------------------------------------
  // Clock source
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xtal_reg      <= 1'b0;
      xtal_prev_reg <= 1'b0;
    end else begin
      xtal_reg      <= crystal_ref_clock;
      xtal_prev_reg <= xtal_reg;
    end
  end

  assign dvi.src_tick = (src_reg == sdbg_src_bus) ? 1'b1 :
                        (xtal_reg && !xtal_prev_reg); // RL11
  assign dvi.psel = psel_reg;
  assign dvi.rsel = rsel_reg;

  // ----------------------------------------------------------------------
  // Baud divider
  // ----------------------------------------------------------------------
  sdbg_baud_div u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .dv      (dvi.div)
  );

  // ----------------------------------------------------------------------
  // Baud ticks
  // ----------------------------------------------------------------------
  assign baud_tick_x32 = dvi.tick_x32;
  assign baud_tick_x16 = dvi.tick_x16; // RL15
  assign baud_bit_tick = dvi.bit_tick; // RL10

endmodule : sdbg_top

// ---- bench/sdbg_assertions.sv ----
`timescale 1ns/1ps
// --------
// Checker
// --------
module sdbg_assertions
  import sdbg_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Shift side and ticks
  input wire logic        rx_load,
  input wire logic [7:0]  rx_shift_byte,
  input wire logic        tx_take,
  input wire logic [7:0]  tx_byte_bits,
  input wire logic        tx_pending,
  input wire logic        baud_tick_x32,
  input wire logic        baud_tick_x16,
  input wire logic        baud_bit_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  wire        rd_ok = avs_read && !avs_waitrequest;
  wire        wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  logic [7:0] rx_reg;
  logic       rx_ok_reg;
  logic       arm_reg;

  always_ff @(posedge sys_clk) begin
    if (rx_load) rx_reg <= rx_shift_byte;
    if (rst) begin
      rx_ok_reg <= 1'b0;
      arm_reg   <= 1'b0;
    end else begin
      if (rx_load) rx_ok_reg <= 1'b1;
      if (rd_ok && avs_address == 8'h24 && avs_readdata[7]) arm_reg <= 1'b1;
      else if (wr_ok && avs_address == 8'h18) arm_reg <= 1'b0;
    end
  end

  sequence s_wr_data;
    wr_ok && avs_address == 8'h18;
  endsequence
  sequence s_rd_data;
    rd_ok && avs_address == 8'h18;
  endsequence

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered");
  a_tx_load: assert property (s_wr_data
    |=> tx_byte_bits == $past(avs_writedata[7:0])) else $error("tx byte");
  a_rx_read: assert property (s_rd_data ##0 $past(rx_ok_reg)
    |-> avs_readdata == {24'h0, $past(rx_reg)}) else $error("rx byte");
  a_rd_zero: assert property (rd_ok && !(avs_address inside
    {8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h30})
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_baud_fmt: assert property (rd_ok && avs_address == 8'h1c
    |-> avs_readdata[31:6] == 26'h0 && !avs_readdata[3])
    else $error("baud select format");
  a_tx_clear: assert property (s_wr_data ##0 (arm_reg && !tx_take)
    |=> tx_pending) else $error("tx empty not cleared");
  a_tick_gap: assert property (baud_tick_x16
    |=> !baud_tick_x16 [*3]) else $error("x16 ticks too close");
  a_tick_nest: assert property (baud_bit_tick
    |-> baud_tick_x16 && baud_tick_x32) else $error("bit tick alone");
endmodule : sdbg_assertions

bind sdbg_top sdbg_assertions u_chk (.sys_clk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .rx_load, .rx_shift_byte, .tx_take, .tx_byte_bits,
  .tx_pending, .baud_tick_x32, .baud_tick_x16, .baud_bit_tick);

// ---- bench/sdbg_shifter_model.sv ----
`timescale 1ns/1ps
// ------------
// Shifter model
// ------------
module sdbg_shifter_model
  import sdbg_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Transmit side
  input  wire logic [7:0] tx_byte_bits,
  input  wire logic       tx_pending,
  output      logic       tx_take,
  // Receive side
  output      logic       rx_load,
  output      logic [7:0] rx_shift_byte
);
  int unsigned take_delay = 3;
  int unsigned wait_cnt = 0;
  sdbg_byte_t  taken_q[$];

  initial begin
    tx_take       = 1'b0;
    rx_load       = 1'b0;
    rx_shift_byte = 8'h00;
  end

  // Takes a pending byte after a settable delay.
  always @(posedge sys_clk) begin
    tx_take <= 1'b0;
    if (rst || !tx_pending || tx_take) wait_cnt <= 0;
    else if (wait_cnt >= take_delay) begin
      tx_take <= 1'b1;
      taken_q.push_back(tx_byte_bits);
      wait_cnt <= 0;
    end else wait_cnt <= wait_cnt + 1;
  end

  // Hands one received byte over; the data lines then carry junk.
  task automatic receive(input sdbg_byte_t b);
    rx_load       <= 1'b1;
    rx_shift_byte <= b;
    @(posedge sys_clk);
    rx_load       <= 1'b0;
    rx_shift_byte <= ~b;
    @(posedge sys_clk);
  endtask : receive
endmodule : sdbg_shifter_model

// ---- bench/test_sdbg_top.sv ----
`timescale 1ns/1ps
module test_sdbg_top
  import sdbg_pkg::*;
;
  // -------
  // Signals
  // -------
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic        crystal_ref_clock = 1'b0;
  logic [2:0]  xtal_cnt = 3'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest, rx_load, tx_take, tx_pending, irq;
  logic [7:0]  rx_shift_byte, tx_byte_bits;
  logic        baud_tick_x32, baud_tick_x16, baud_bit_tick;
  logic [31:0] exp_q[$];
  logic [7:0]  zero_a[7] = '{8'h1c, 8'h20, 8'h28, 8'h2c, 8'h30, 8'h00, 8'h3c};
  sdbg_byte_t  rx_b, tx_b;
  int          fail_count = 0;
  int          total_checks = 0;
  int          n, pd, r;

  always #12.5 sys_clk = ~sys_clk;
  // Crystal reference at one eighth of the bus clock.
  always @(posedge sys_clk) begin
    xtal_cnt          <= xtal_cnt + 3'h1;
    crystal_ref_clock <= xtal_cnt[2];
  end

  sdbg_top u_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .crystal_ref_clock, .rx_load, .rx_shift_byte, .tx_take, .tx_byte_bits,
    .tx_pending, .baud_tick_x32, .baud_tick_x16, .baud_bit_tick, .irq);
  sdbg_shifter_model u_far (.sys_clk, .rst, .tx_byte_bits, .tx_pending,
    .rx_load, .rx_shift_byte, .tx_take);

  // -----
  // Tasks
  // -----
  task results;
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask : check

  task bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    int k;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    if (rd) avs_read <= 1'b1;
    else avs_write <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      results();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b1, a, 8'h00);
  endtask : rd

  task automatic gap(input int k, output int c);
    logic s;
    for (int i = 0; i < 3; i++) begin
      c = 0;
      do begin
        @(posedge sys_clk);
        c++;
        s = k == 0 ? baud_tick_x32 : k == 1 ? baud_tick_x16 : baud_bit_tick;
      end while (s !== 1'b1 && c < 9000);
      if (s !== 1'b1) begin
        fail_count++;
        results();
      end
    end
  endtask : gap

  // Read results are compared against the oldest note.
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() > 0) check(avs_readdata, exp_q.pop_front());
      else fail_count++;
    end
  end

  // --------
  // Sequence
  // --------
  initial begin
    void'($urandom(76049));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (zero_a[i]) rd(zero_a[i], 32'h0);
    bus(1'b0, 8'h1c, 8'hff);
    rd(8'h1c, 32'h37);
    avs_byteenable <= 4'h0;
    bus(1'b0, 8'h1c, 8'h00);
    avs_byteenable <= 4'h1;
    rd(8'h1c, 32'h37);
    rx_b = 8'($urandom);
    tx_b = 8'($urandom);
    u_far.receive(rx_b);
    bus(1'b0, 8'h18, tx_b);
    check(32'(tx_pending), 32'h0);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h18, {24'h0, rx_b});
    rd(8'h1c, 32'h0);
    check({24'h0, tx_byte_bits}, {24'h0, tx_b});
    rx_b = 8'($urandom);
    u_far.receive(rx_b);
    rd(8'h18, {24'h0, rx_b});
    rd(8'h24, 32'ha0);
    rd(8'h18, {24'h0, rx_b});
    rd(8'h24, 32'h80);
    bus(1'b0, 8'h30, 8'h02);
    check(32'(irq), 32'h0);
    u_far.take_delay = $urandom_range(20, 1);
    tx_b = 8'($urandom);
    bus(1'b0, 8'h18, tx_b);
    rd(8'h18, {24'h0, rx_b});
    n = 0;
    while (u_far.taken_q.size() == 0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (u_far.taken_q.size() == 0) begin
      fail_count++;
      results();
    end
    repeat (3) @(posedge sys_clk);
    check({24'h0, u_far.taken_q.pop_front()}, {24'h0, tx_b});
    check(32'(tx_pending), 32'h0);
    check(32'(irq), 32'h1);
    rd(8'h28, 32'h3);
    bus(1'b0, 8'h2c, 8'h02);
    check(32'(irq), 32'h0);
    rd(8'h28, 32'h1);
    bus(1'b0, 8'h30, 8'h03);
    check(32'(irq), 32'h1);
    bus(1'b0, 8'h2c, 8'h01);
    check(32'(irq), 32'h0);
    for (r = 0; r < 8; r++) begin
      bus(1'b0, 8'h1c, 8'(r));
      gap(1, n);
      check(n, 32'h4 << r);
    end
    for (int p = 0; p < 4; p++) begin
      pd = (p == 0) ? 1 : (p == 1) ? 3 : (p == 2) ? 4 : 13;
      r = $urandom_range(1, 0);
      bus(1'b0, 8'h1c, 8'(p * 16 + r));
      rd(8'h1c, 32'(p * 16 + r));
      gap(2, n);
      check(n, 32'(64 * pd) << r);
      gap(0, n);
      check(n, 32'(2 * pd) << r);
    end
    bus(1'b0, 8'h1c, 8'h00);
    bus(1'b0, 8'h20, 8'h01);
    rd(8'h20, 32'h1);
    gap(1, n);
    check(n, 32'h20);
    results();
  end
endmodule : test_sdbg_top
